// ==== rtl/pmd_ctrl.v ====
// host-side controller for a 256k x 1 page mode dram
// assumes the dram pins connect directly; q is sampled through a synchroniser
`include "pmd_defs.vh"

module pmd_ctrl #(
    parameter PWRUP_CYC   = `PMD_PWRUP_CYC,
    parameter REF_INT_CYC = `PMD_REF_INT_CYC
) (
    input  wire                    mclk,
    input  wire                    reset_n,
    input  wire                    req_valid,
    output wire                    req_ready,
    input  wire                    req_write,
    input  wire                    req_page,
    input  wire [`PMD_ADDR_W-1:0]  req_addr,
    input  wire                    req_wdata,
    output reg                     rd_valid,
    output reg                     rd_data,
    output reg                     init_done,
    output reg  [`PMD_MUX_W-1:0]   mux_addr_pins,
    output reg                     ras_n,
    output reg                     cas_n,
    output reg                     we_n,
    output reg                     din,
    input  wire                    dout
);
    localparam ST_PWRUP  = 4'h0;
    localparam ST_IDLE   = 4'h1;
    localparam ST_ROW    = 4'h2;
    localparam ST_COL    = 4'h3;
    localparam ST_CASLO  = 4'h4;
    localparam ST_PAGE   = 4'h5;
    localparam ST_CASHI  = 4'h6;
    localparam ST_PRECH  = 4'h7;
    localparam ST_CBR_C  = 4'h8;
    localparam ST_CBR_R  = 4'h9;
    localparam ST_WAKE   = 4'ha;

    localparam CW = 22;

    // counts sized to the counter so no load drops or pads bits
    localparam [CW-1:0] K_PWRUP    = PWRUP_CYC;
    localparam [CW-1:0] K_REF_M1   = REF_INT_CYC - 1;
    localparam [CW-1:0] K_RASP_LIM = `PMD_RASP_MAX_CYC - `PMD_RASP_MARGIN;
    localparam [CW-1:0] K_RAS_MIN  = `PMD_RAS_MIN_CYC;
    localparam [CW-1:0] K_RAS_M1   = `PMD_RAS_MIN_CYC - 1;
    localparam [CW-1:0] K_RP_M1    = `PMD_RP_CYC - 1;
    localparam [CW-1:0] K_RC       = `PMD_RC_CYC;
    localparam [CW-1:0] K_CP       = `PMD_CP_CYC;
    localparam [CW-1:0] K_CSR_M1   = `PMD_CSR_CYC - 1;
    // read waits the access time plus the synchroniser latency
    localparam [CW-1:0] K_ACC      = `PMD_CAC_CYC + `PMD_SYNC_LAT;
    localparam [3:0]    K_WAKE     = `PMD_WAKE_CYCLES;

    reg  [3:0]            state_reg;
    reg  [CW-1:0]         cnt_reg;
    reg  [CW-1:0]         ras_cnt_reg;
    reg  [CW-1:0]         ref_cnt_reg;
    reg  [8:0]            ref_owed_reg;
    reg  [3:0]            wake_reg;
    reg  [`PMD_ADDR_W-1:0] addr_reg;
    reg                   wr_reg;
    reg                   page_reg;
    wire                  dout_s;

    pmd_sync3 u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .d       (dout),
        .q       (dout_s)
    );

    wire cnt_done   = (cnt_reg == {CW{1'b0}});
    // ready only while a page is open on the same row, or idle with no refresh owed
    wire same_row   = (req_addr[`PMD_ADDR_W-1:`PMD_ROW_LSB] ==
                       addr_reg[`PMD_ADDR_W-1:`PMD_ROW_LSB]);
    wire rasp_left  = (ras_cnt_reg < K_RASP_LIM);
    // a request without req_page waits until the page has closed
    wire page_ok    = (state_reg == ST_PAGE) && cnt_done && same_row && rasp_left &&
                      req_page && (ref_owed_reg == 9'h000);
    assign req_ready = init_done && cnt_done && (ref_owed_reg == 9'h000) &&
                       ((state_reg == ST_IDLE) || page_ok);

    // ------------------------------------------------------------------
    // refresh debt
    // ------------------------------------------------------------------
    wire ref_tick = (ref_cnt_reg == {CW{1'b0}});
    wire ref_done = (state_reg == ST_CBR_R) && cnt_done;
    always @(posedge mclk) begin
        if (!reset_n) begin
            ref_cnt_reg  <= {CW{1'b0}};
            ref_owed_reg <= 9'h000;
        end else begin
            ref_cnt_reg <= ref_tick ? K_REF_M1 : ref_cnt_reg - 1'b1;
            if (init_done) begin
                case ({ref_tick, ref_done})
                    2'b10:   ref_owed_reg <= ref_owed_reg + 1'b1;
                    2'b01:   ref_owed_reg <= ref_owed_reg - 1'b1;
                    default: ref_owed_reg <= ref_owed_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // main sequencer
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        if (!reset_n) begin
            state_reg     <= ST_PWRUP;
            cnt_reg       <= {CW{1'b0}};
            ras_cnt_reg   <= {CW{1'b0}};
            wake_reg      <= 4'h0;
            addr_reg      <= {`PMD_ADDR_W{1'b0}};
            wr_reg        <= 1'b0;
            page_reg      <= 1'b0;
            init_done     <= 1'b0;
            mux_addr_pins <= {`PMD_MUX_W{1'b0}};
            ras_n         <= 1'b1;
            cas_n         <= 1'b1;
            we_n          <= 1'b1;
            din           <= 1'b0;
            rd_valid      <= 1'b0;
            rd_data       <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            if (!cnt_done) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            ras_cnt_reg <= ras_n ? {CW{1'b0}} : ras_cnt_reg + 1'b1;
            case (state_reg)
                ST_PWRUP: begin
                    if (cnt_reg == {CW{1'b0}} && wake_reg == 4'h0) begin
                        cnt_reg  <= K_PWRUP;
                        wake_reg <= 4'h1;
                    end else if (cnt_done) begin
                        wake_reg  <= 4'h0;
                        state_reg <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (cnt_done) begin
                        if (ras_n) begin
                            if (wake_reg == K_WAKE) begin
                                init_done <= 1'b1;
                                state_reg <= ST_IDLE;
                            end else begin
                                ras_n   <= 1'b0;
                                cnt_reg <= K_RAS_M1;
                            end
                        end else begin
                            ras_n    <= 1'b1;
                            wake_reg <= wake_reg + 1'b1;
                            cnt_reg  <= K_RP_M1;
                        end
                    end
                end
                ST_IDLE: begin
                    if (cnt_done && init_done && ref_owed_reg != 9'h000) begin
                        cas_n     <= 1'b0;
                        cnt_reg   <= K_CSR_M1;
                        state_reg <= ST_CBR_C;
                    end else if (req_valid && req_ready) begin
                        addr_reg  <= req_addr;
                        wr_reg    <= req_write;
                        page_reg  <= req_page;
                        din       <= req_wdata;
                        mux_addr_pins <= req_addr[`PMD_ADDR_W-1:`PMD_ROW_LSB];
                        state_reg <= ST_ROW;
                    end
                end
                ST_ROW: begin
                    ras_n     <= 1'b0;
                    state_reg <= ST_COL;
                end
                ST_COL: begin
                    // column half; column address before strobe
                    mux_addr_pins <= addr_reg[`PMD_ROW_LSB-1:0];
                    we_n      <= ~wr_reg;
                    state_reg <= ST_CASLO;
                    cnt_reg   <= {CW{1'b0}};
                end
                ST_CASLO: begin
                    cas_n     <= 1'b0;
                    cnt_reg   <= K_ACC;
                    state_reg <= ST_CASHI;
                end
                ST_CASHI: begin
                    // access from column strobe, plus synchroniser delay
                    if (cnt_done) begin
                        if (!wr_reg) begin
                            rd_valid <= 1'b1;
                            rd_data  <= dout_s;
                        end
                        // write select held past column rise
                        cas_n     <= 1'b1;
                        cnt_reg   <= K_CP;
                        state_reg <= page_reg ? ST_PAGE : ST_PRECH;
                    end
                end
                ST_PAGE: begin
                    we_n <= 1'b1;
                    if (page_ok && req_valid && req_page) begin
                        addr_reg      <= req_addr;
                        wr_reg        <= req_write;
                        din           <= req_wdata;
                        mux_addr_pins <= req_addr[`PMD_ROW_LSB-1:0];
                        we_n          <= ~req_write;
                        state_reg     <= ST_CASLO;
                    end else if (cnt_done && ras_cnt_reg >= K_RAS_MIN) begin
                        // close page when idle or too long
                        state_reg <= ST_PRECH;
                        cnt_reg   <= {CW{1'b0}};
                    end
                end
                ST_PRECH: begin
                    if (cnt_done && ras_cnt_reg >= K_RAS_MIN) begin
                        ras_n     <= 1'b1;
                        we_n      <= 1'b1;
                        cnt_reg   <= K_RC;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_CBR_C: begin
                    if (cnt_done) begin
                        ras_n     <= 1'b0;
                        cnt_reg   <= K_RAS_MIN;
                        state_reg <= ST_CBR_R;
                    end
                end
                ST_CBR_R: begin
                    if (cnt_done) begin
                        ras_n     <= 1'b1;
                        // no counter test: column strobe rises with row strobe
                        cas_n     <= 1'b1;
                        cnt_reg   <= K_RC;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // pmd_ctrl

// ==== shared/pmd_defs.vh ====
// constants for the page mode dram controller: pin widths and timing counts
// assumes a 20 mhz mclk; times are in ns (or us/ms) and counts derived here
`ifndef PMD_DEFS_VH
`define PMD_DEFS_VH

`define PMD_CLK_NS          50
`define PMD_ADDR_W          18
`define PMD_MUX_W           9
`define PMD_ROW_LSB         9
// power-up pause and wake-up row strobes
`define PMD_PWRUP_US        200
`define PMD_PWRUP_CYC       ((`PMD_PWRUP_US * 1000) / `PMD_CLK_NS)
`define PMD_WAKE_CYCLES     8
// refresh: 256 rows each 4 ms
`define PMD_REF_ROWS        256
`define PMD_REF_MS          4
`define PMD_REF_INT_CYC     ((`PMD_REF_MS * 1000000) / (`PMD_REF_ROWS * `PMD_CLK_NS))
// strobe timing (fastest grade), least times rounded up
`define PMD_RAS_MIN_NS      70
`define PMD_RAS_MIN_CYC     ((`PMD_RAS_MIN_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_RP_NS           50
`define PMD_RP_CYC          ((`PMD_RP_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_RC_NS           130
`define PMD_RC_CYC          ((`PMD_RC_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_PC_NS           45
`define PMD_PC_CYC          ((`PMD_PC_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_CP_NS           10
`define PMD_CP_CYC          ((`PMD_CP_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_CAC_NS          20
`define PMD_CAC_CYC         ((`PMD_CAC_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_CSR_NS          10
`define PMD_CSR_CYC         ((`PMD_CSR_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
`define PMD_CPT_NS          35
`define PMD_CPT_CYC         ((`PMD_CPT_NS + `PMD_CLK_NS - 1) / `PMD_CLK_NS)
// page row active longest time, rounded down
`define PMD_RASP_MAX_NS     100000
`define PMD_RASP_MAX_CYC    (`PMD_RASP_MAX_NS / `PMD_CLK_NS)
// page closes this many cycles early so one last access still fits
`define PMD_RASP_MARGIN     16
// read sample waits for the three input stages and the agreement flop
`define PMD_SYNC_LAT        3

`endif

// ==== rtl/pmd_sync3.v ====
// three-stage input synchroniser with agreement of the last two stages
// assumes d comes from outside the mclk domain
module pmd_sync3 (
    input  wire mclk,
    input  wire reset_n,
    input  wire d,
    output reg  q
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge mclk) begin
        if (!reset_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q      <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // only a settled level counts
            if (s2_reg == s3_reg) begin
                q <= s3_reg;
            end
        end
    end
endmodule // pmd_sync3

// ==== tb/pmd_ctrl_properties.sv ====
// checker: strobe order, spacing and refresh duty of pmd_ctrl
// assumes it is bound to pmd_ctrl and sees only its ports
`include "pmd_defs.vh"
module pmd_ctrl_properties #(
    parameter PWRUP_CYC   = 20,
    parameter REF_INT_CYC = 50
) (
    input logic                   mclk,
    input logic                   reset_n,
    input logic                   req_valid,
    input logic                   req_ready,
    input logic                   req_write,
    input logic [`PMD_ADDR_W-1:0] req_addr,
    input logic                   req_wdata,
    input logic                   init_done,
    input logic [`PMD_MUX_W-1:0]  mux_addr_pins,
    input logic                   ras_n,
    input logic                   cas_n,
    input logic                   we_n,
    input logic                   din
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ------------------------------
    // helper state
    // ------------------------------
    logic [17:0] a_reg;
    logic        w_reg, d_reg, ras_reg;
    logic [11:0] gap_reg, low_reg, rgap_reg;
    logic [3:0]  wake_reg;
    wire         fall = ras_reg && !ras_n;
    always @(posedge mclk) begin
        ras_reg <= ras_n;
        low_reg <= ras_n ? 12'h000 : low_reg + 12'h001;
        if (req_valid && req_ready) begin
            a_reg <= req_addr;
            w_reg <= req_write;
            d_reg <= req_wdata;
        end
        if (!reset_n) begin
            gap_reg <= 12'hfff;
            wake_reg <= 4'h0;
            rgap_reg <= 12'h000;
        end else begin
            gap_reg <= fall ? 12'h001 : gap_reg + {11'h000, gap_reg != 12'hfff};
            if (!init_done && fall && wake_reg != 4'hf)
                wake_reg <= wake_reg + 4'h1;
            // refresh gap only counts once the part is awake
            rgap_reg <= (!init_done || (fall && !cas_n)) ? 12'h000 : rgap_reg + 12'h001;
        end
    end
    // ------------------------------
    // properties
    // ------------------------------
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        !reset_n |=> ras_n && cas_n && we_n && !init_done) else $error("strobes busy in reset");
    AST_NO_EARLY_REQ: assert property (!init_done |-> !req_ready)
        else $error("request taken before init");
    AST_WAKE_COUNT: assert property ($rose(init_done) |-> wake_reg >= 4'h8)
        else $error("too few wake row strobes");
    AST_ROW_ADDR: assert property ($fell(ras_n) && cas_n && init_done
        |-> mux_addr_pins == a_reg[17:9]) else $error("wrong row address");
    AST_COL_ADDR: assert property ($fell(cas_n) && !ras_n
        |-> mux_addr_pins == a_reg[8:0]) else $error("wrong column address");
    AST_EARLY_WRITE: assert property ($fell(cas_n) && !ras_n
        |-> we_n != w_reg && (we_n || din == d_reg)) else $error("write not early");
    AST_READ_HOLD: assert property (!ras_n && !cas_n && we_n |=> we_n)
        else $error("write select dropped in read");
    AST_CBR_SETUP: assert property ($fell(ras_n) && !cas_n |-> !$past(cas_n) ##1 !cas_n)
        else $error("refresh column setup short");
    AST_RC_SPACING: assert property ($fell(ras_n) |-> gap_reg >= `PMD_RC_CYC)
        else $error("row cycles too close");
    AST_RAS_WIDTH: assert property ($fell(ras_n) |-> !ras_n [*2])
        else $error("row strobe too short");
    AST_RASP_MAX: assert property (!ras_n |-> low_reg < `PMD_RASP_MAX_CYC)
        else $error("row strobe held too long");
    AST_CAS_PRECHARGE: assert property ($rose(cas_n) && !ras_n |=> cas_n)
        else $error("column precharge too short");
    AST_REFRESH_GAP: assert property (init_done |-> rgap_reg <= 2 * REF_INT_CYC)
        else $error("refresh overdue");
endmodule // pmd_ctrl_properties

bind pmd_ctrl pmd_ctrl_properties #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .init_done(init_done), .mux_addr_pins(mux_addr_pins), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .din(din));

// ==== tb/pmd_dram_model.sv ====
// behavioural 256k x 1 page mode dram, strobe edge driven
// assumes pins driven by the controller; output idles to inverse of last bit
module pmd_dram_model #(
    parameter CAC_NS = 20
) (
    input  logic [8:0] mux_addr_pins,
    input  logic       ras_n,
    input  logic       cas_n,
    input  logic       we_n,
    input  logic       din,
    output logic       dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       mem [0:262143];
    logic [8:0] row, col;
    logic [7:0] ref_cnt = 8'h00;
    logic [3:0] wake = 4'h0;
    logic       cbr = 1'b0;
    logic       last = 1'b0;
    initial dout = 1'b1;
    always @(negedge ras_n) begin
        cbr = !cas_n;
        if (wake != 4'hf) wake = wake + 4'h1;
        if (cbr) ref_cnt = ref_cnt + 8'h01;
        else row = mux_addr_pins;
    end
    // early write or read, address set before column strobe
    always @(negedge cas_n) if (!ras_n && !cbr) begin
        col = mux_addr_pins;
        if (!we_n) begin
            if (wake >= 4'h8) mem[{row, col}] = din;
        end else begin
            last = mem[{row, col}];
            dout <= #CAC_NS last;
        end
    end
    // late write keeps old bit out; the controller never times one
    always @(negedge we_n) if (!ras_n && !cas_n && !cbr) mem[{row, col}] = din;
    always @(posedge cas_n) dout <= #5 ~last;
endmodule // pmd_dram_model

// ==== tb/tb_top.sv ====
// self-checking bench for pmd_ctrl against a behavioural dram
// assumes shortened power-up and refresh counts; all compares via one macro
`include "pmd_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
    logic        mclk = 0, reset_n = 0, req_valid = 0, req_write = 0;
    logic        req_page = 0, req_wdata = 0, exp_b;
    logic [17:0] req_addr = 18'h00000;
    logic [17:0] at [16];
    logic        shadow [logic [17:0]];
    logic        exp_q [$];
    wire         req_ready, rd_valid, rd_data, init_done, ras_n, cas_n, we_n, din, dout;
    wire  [8:0]  mux_addr_pins;
    int          fails = 0, compares = 0, wake_n = 0;
    logic [7:0]  r0;
    pmd_ctrl #(.PWRUP_CYC(20), .REF_INT_CYC(50)) u_pmd_ctrl (
        .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_page(req_page), .req_addr(req_addr),
        .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
        .init_done(init_done), .mux_addr_pins(mux_addr_pins), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .din(din), .dout(dout));
    pmd_dram_model u_pmd_dram_model (.mux_addr_pins(mux_addr_pins), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .din(din), .dout(dout));
    initial forever #25 mclk = ~mclk;
    // ------------------------------
    // driver and monitor
    // ------------------------------
    task automatic acc(input logic w, p, input logic [17:0] a, input logic d);
        int k;
        k = 0;
        @(posedge mclk);
        req_valid <= 1;
        req_write <= w;
        req_page <= p;
        req_addr <= a;
        req_wdata <= d;
        do begin @(negedge mclk); k++; end while (req_ready !== 1'b1 && k < 3000);
        if (req_ready !== 1'b1) begin
            fails++;
            final_report();
        end
        @(posedge mclk);
        req_valid <= 0;
        if (w) shadow[a] = d;
        else exp_q.push_back(shadow[a]);
    endtask
    // wake row strobes seen on the pins before the controller reports ready
    always @(negedge ras_n) if (init_done !== 1'b1) wake_n++;
    always @(negedge mclk) if (rd_valid === 1'b1) begin
        exp_b = exp_q.size() ? exp_q.pop_front() : ~rd_data;
        `CHK(rd_data, exp_b)
    end
    task automatic final_report();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wake_up();
        wake_n = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1;
        while (init_done !== 1'b1) @(posedge mclk);
        `CHK(wake_n >= 8, 1'b1)
    endtask
    initial begin
        #500us;
        fails++;
        final_report();
    end
    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        void'($urandom(32'h37a5));
        wake_up();
        at[0] = 18'h00000;
        at[1] = 18'h3ffff;
        for (int i = 2; i < 16; i++) at[i] = 18'($urandom);
        for (int i = 0; i < 16; i++) acc(1, 0, at[i], 1'($urandom));
        for (int i = 15; i >= 0; i--) acc(0, 0, at[i], 0);
        // same row, several columns with the page held open
        r0 = 8'($urandom);
        for (int i = 0; i < 6; i++) acc(1, i < 5, {1'b1, r0, 9'(i * 97)}, 1'(i));
        for (int i = 0; i < 6; i++) acc(0, i < 5, {1'b1, r0, 9'(i * 97)}, 0);
        // idle: refreshes must keep coming and cells keep their bits
        r0 = u_pmd_dram_model.ref_cnt;
        repeat (400) @(posedge mclk);
        `CHK(8'(u_pmd_dram_model.ref_cnt - r0) >= 8'd7, 1'b1)
        for (int i = 0; i < 16; i++) acc(0, 0, at[i], 0);
        repeat (20) @(posedge mclk);
        // reset in mid-run, then wake again
        reset_n <= 0;
        repeat (2) @(posedge mclk);
        `CHK({ras_n, cas_n, we_n, init_done}, 4'b1110)
        wake_up();
        acc(1, 0, at[5], ~shadow[at[5]]);
        acc(0, 0, at[5], 0);
        repeat (20) @(posedge mclk);
        `CHK(exp_q.size(), 0)
        final_report();
    end
endmodule // tb_top
